//--- inc/enable_clear_pkg.sv
// Package: offsets, field layout, masks and reset values of the enable bank
package enable_clear_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // ************************************************************
    // Register offsets (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [ADDR_W-1:0] ENABLE_SET_OFFSET   = 8'h00;
    localparam logic [ADDR_W-1:0] ENABLE_CLEAR_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] MODE_CTRL_OFFSET    = 8'h08;

    // ************************************************************
    // Enable bit positions
    // ************************************************************
    localparam int unsigned BIT_ERROR_POS          = 31;
    localparam int unsigned PHYSICAL_BUS_ERROR_POS = 30;
    localparam int unsigned CHECKSUM_ERROR_POS     = 29;
    localparam int unsigned SYNC_FIELD_ERROR_POS   = 28;
    localparam int unsigned NO_RESPONSE_POS        = 27;
    localparam int unsigned FRAMING_ERROR_POS      = 26;
    localparam int unsigned OVERRUN_POS            = 25;
    localparam int unsigned PARITY_ERROR_POS       = 24;
    localparam int unsigned ID_POS                 = 13;
    localparam int unsigned RECEIVE_POS            = 9;
    localparam int unsigned TRANSMIT_POS           = 8;
    localparam int unsigned TIMEOUT_THREE_POS      = 7;
    localparam int unsigned TIMEOUT_ONE_POS        = 6;
    localparam int unsigned BUS_IDLE_TIMEOUT_POS   = 4;
    localparam int unsigned WAKEUP_POS             = 1;
    localparam int unsigned BREAK_DETECT_POS       = 0;

    // Mode control field
    localparam int unsigned LIN_MODE_POS = 0;

    // ************************************************************
    // Field masks
    // ************************************************************
    // Every enable that exists; all other bits are reserved
    localparam logic [DATA_W-1:0] IMPLEMENTED_MASK = 32'hFF0023D3;
    // Enables that software may change only in LIN mode
    localparam logic [DATA_W-1:0] LIN_ONLY_MASK    = 32'hF80020D0;
    // Enables that software may change only in SCI-compatible mode
    localparam logic [DATA_W-1:0] SCI_ONLY_MASK    = 32'h00000001;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] ENABLE_RESET   = 32'h00000000;
    localparam logic              LIN_MODE_RESET = 1'b0;
    localparam logic [DATA_W-1:0] READ_IDLE      = 32'h00000000;

endpackage

//--- logic/enable_bank.sv
// Enable storage: one flip-flop per interrupt enable, set and cleared by masks
module enable_bank
    import enable_clear_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // Gated write masks
    input  wire logic [DATA_W-1:0] set_mask,
    input  wire logic [DATA_W-1:0] clear_mask,
    // Enable state
    output logic      [DATA_W-1:0] enable_q
);

    // ************************************************************
    // Per-bit storage
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < DATA_W; i++) begin : g_bit
            if (IMPLEMENTED_MASK[i]) begin : g_impl
                // Shared by set and clear registers
                always_ff @(posedge ref_clk or negedge reset_n) begin
                    if (!reset_n) begin
                        enable_q[i] <= ENABLE_RESET[i];
                    end else if (clear_mask[i]) begin
                        enable_q[i] <= 1'b0;
                    end else if (set_mask[i]) begin
                        enable_q[i] <= 1'b1;
                    end
                end
            end else begin : g_rsvd
                // Reserved bits hold no state
                assign enable_q[i] = 1'b0;
            end
        end
    endgenerate

endmodule

//--- logic/interrupt_enable_clear.sv
// Interrupt enable bank: set register, write-one-to-clear register, mode control
//
// Local design decisions: the strobed register port and the register addresses.
module interrupt_enable_clear
    import enable_clear_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [DATA_W-1:0] reg_rdata,
    // Enable state towards the event logic
    output logic      [DATA_W-1:0] interrupt_enable,
    output logic                   lin_mode
);

    // ************************************************************
    // Decoding helpers
    // ************************************************************
    // Bits software may change in the present mode
    function automatic logic [DATA_W-1:0] writable_mask(input logic lin);
        logic [DATA_W-1:0] m;
        m = IMPLEMENTED_MASK;
        if (lin) begin
            m = m & ~SCI_ONLY_MASK;
        end else begin
            m = m & ~LIN_ONLY_MASK;
        end
        return m;
    endfunction

    // Address match for one register
    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] offset);
        return addr == offset;
    endfunction

    // ************************************************************
    // Internal signals
    // ************************************************************
    logic              lin_mode_q;
    logic [DATA_W-1:0] enable_q;
    logic [DATA_W-1:0] set_mask;
    logic [DATA_W-1:0] clear_mask;
    logic [DATA_W-1:0] set_lanes;
    logic [DATA_W-1:0] clear_lanes;
    logic [DATA_W-1:0] enable_image;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;

    // ************************************************************
    // Write decode
    // ************************************************************
    // Set strobes, gated by mode
    always_comb begin
        set_mask = '0;
        if (reg_write && hit(reg_addr, ENABLE_SET_OFFSET)) begin
            set_mask = reg_wdata & writable_mask(lin_mode_q);
        end
    end

    // Clear strobes: ones drop enables, zeros leave them
    always_comb begin
        clear_mask = '0;
        if (reg_write && hit(reg_addr, ENABLE_CLEAR_OFFSET)) begin
            clear_mask = reg_wdata & writable_mask(lin_mode_q);
        end
    end

    // ************************************************************
    // Named clear lanes
    // ************************************************************
    // One strobe per enable-clear field, already gated by mode.
    // A read-modify-write of this word writes back every enable that
    // reads one and so drops those writable in the present mode: software must write whole words.
    logic clear_bit_error_enable;
    logic clear_physical_bus_error_enable;
    logic clear_checksum_error_enable;
    logic clear_sync_field_error_enable;
    logic clear_no_response_enable;
    logic clear_framing_error_enable;
    logic clear_overrun_enable;
    logic clear_parity_error_enable;
    logic clear_id_enable;
    logic clear_receive_enable;
    logic clear_transmit_enable;
    logic clear_timeout_three_wakeups_enable;
    logic clear_timeout_one_wakeup_enable;
    logic clear_bus_idle_timeout_enable;
    logic clear_wakeup_enable;
    logic clear_break_detect_enable;

    // Lane taps from the gated clear word
    assign clear_bit_error_enable             = clear_mask[BIT_ERROR_POS];
    assign clear_physical_bus_error_enable    = clear_mask[PHYSICAL_BUS_ERROR_POS];
    assign clear_checksum_error_enable        = clear_mask[CHECKSUM_ERROR_POS];
    assign clear_sync_field_error_enable      = clear_mask[SYNC_FIELD_ERROR_POS];
    assign clear_no_response_enable           = clear_mask[NO_RESPONSE_POS];
    assign clear_framing_error_enable         = clear_mask[FRAMING_ERROR_POS];
    assign clear_overrun_enable               = clear_mask[OVERRUN_POS];
    assign clear_parity_error_enable          = clear_mask[PARITY_ERROR_POS];
    assign clear_id_enable                    = clear_mask[ID_POS];
    assign clear_receive_enable               = clear_mask[RECEIVE_POS];
    assign clear_transmit_enable              = clear_mask[TRANSMIT_POS];
    assign clear_timeout_three_wakeups_enable = clear_mask[TIMEOUT_THREE_POS];
    assign clear_timeout_one_wakeup_enable    = clear_mask[TIMEOUT_ONE_POS];
    assign clear_bus_idle_timeout_enable      = clear_mask[BUS_IDLE_TIMEOUT_POS];
    assign clear_wakeup_enable                = clear_mask[WAKEUP_POS];
    assign clear_break_detect_enable          = clear_mask[BREAK_DETECT_POS];

    // Clear word towards the bank; reserved lanes stay low
    always_comb begin
        clear_lanes                         = '0;
        clear_lanes[BIT_ERROR_POS]          = clear_bit_error_enable;
        clear_lanes[PHYSICAL_BUS_ERROR_POS] = clear_physical_bus_error_enable;
        clear_lanes[CHECKSUM_ERROR_POS]     = clear_checksum_error_enable;
        clear_lanes[SYNC_FIELD_ERROR_POS]   = clear_sync_field_error_enable;
        clear_lanes[NO_RESPONSE_POS]        = clear_no_response_enable;
        clear_lanes[FRAMING_ERROR_POS]      = clear_framing_error_enable;
        clear_lanes[OVERRUN_POS]            = clear_overrun_enable;
        clear_lanes[PARITY_ERROR_POS]       = clear_parity_error_enable;
        clear_lanes[ID_POS]                 = clear_id_enable;
        clear_lanes[RECEIVE_POS]            = clear_receive_enable;
        clear_lanes[TRANSMIT_POS]           = clear_transmit_enable;
        clear_lanes[TIMEOUT_THREE_POS]      = clear_timeout_three_wakeups_enable;
        clear_lanes[TIMEOUT_ONE_POS]        = clear_timeout_one_wakeup_enable;
        clear_lanes[BUS_IDLE_TIMEOUT_POS]   = clear_bus_idle_timeout_enable;
        clear_lanes[WAKEUP_POS]             = clear_wakeup_enable;
        clear_lanes[BREAK_DETECT_POS]       = clear_break_detect_enable;
    end

    // ************************************************************
    // Named set lanes
    // ************************************************************
    // One strobe per enable-set field, gated by the same mode rules
    logic set_bit_error_enable;
    logic set_physical_bus_error_enable;
    logic set_checksum_error_enable;
    logic set_sync_field_error_enable;
    logic set_no_response_enable;
    logic set_framing_error_enable;
    logic set_overrun_enable;
    logic set_parity_error_enable;
    logic set_id_enable;
    logic set_receive_enable;
    logic set_transmit_enable;
    logic set_timeout_three_wakeups_enable;
    logic set_timeout_one_wakeup_enable;
    logic set_bus_idle_timeout_enable;
    logic set_wakeup_enable;
    logic set_break_detect_enable;

    // Lane taps from the gated set word
    assign set_bit_error_enable             = set_mask[BIT_ERROR_POS];
    assign set_physical_bus_error_enable    = set_mask[PHYSICAL_BUS_ERROR_POS];
    assign set_checksum_error_enable        = set_mask[CHECKSUM_ERROR_POS];
    assign set_sync_field_error_enable      = set_mask[SYNC_FIELD_ERROR_POS];
    assign set_no_response_enable           = set_mask[NO_RESPONSE_POS];
    assign set_framing_error_enable         = set_mask[FRAMING_ERROR_POS];
    assign set_overrun_enable               = set_mask[OVERRUN_POS];
    assign set_parity_error_enable          = set_mask[PARITY_ERROR_POS];
    assign set_id_enable                    = set_mask[ID_POS];
    assign set_receive_enable               = set_mask[RECEIVE_POS];
    assign set_transmit_enable              = set_mask[TRANSMIT_POS];
    assign set_timeout_three_wakeups_enable = set_mask[TIMEOUT_THREE_POS];
    assign set_timeout_one_wakeup_enable    = set_mask[TIMEOUT_ONE_POS];
    assign set_bus_idle_timeout_enable      = set_mask[BUS_IDLE_TIMEOUT_POS];
    assign set_wakeup_enable                = set_mask[WAKEUP_POS];
    assign set_break_detect_enable          = set_mask[BREAK_DETECT_POS];

    // Set word towards the bank; reserved lanes stay low
    always_comb begin
        set_lanes                         = '0;
        set_lanes[BIT_ERROR_POS]          = set_bit_error_enable;
        set_lanes[PHYSICAL_BUS_ERROR_POS] = set_physical_bus_error_enable;
        set_lanes[CHECKSUM_ERROR_POS]     = set_checksum_error_enable;
        set_lanes[SYNC_FIELD_ERROR_POS]   = set_sync_field_error_enable;
        set_lanes[NO_RESPONSE_POS]        = set_no_response_enable;
        set_lanes[FRAMING_ERROR_POS]      = set_framing_error_enable;
        set_lanes[OVERRUN_POS]            = set_overrun_enable;
        set_lanes[PARITY_ERROR_POS]       = set_parity_error_enable;
        set_lanes[ID_POS]                 = set_id_enable;
        set_lanes[RECEIVE_POS]            = set_receive_enable;
        set_lanes[TRANSMIT_POS]           = set_transmit_enable;
        set_lanes[TIMEOUT_THREE_POS]      = set_timeout_three_wakeups_enable;
        set_lanes[TIMEOUT_ONE_POS]        = set_timeout_one_wakeup_enable;
        set_lanes[BUS_IDLE_TIMEOUT_POS]   = set_bus_idle_timeout_enable;
        set_lanes[WAKEUP_POS]             = set_wakeup_enable;
        set_lanes[BREAK_DETECT_POS]       = set_break_detect_enable;
    end

    // Mode control register.
    // A new mode governs only writes after the one that sets it;
    // a write in the same cycle is still gated by the old mode.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lin_mode_q <= LIN_MODE_RESET;
        end else if (reg_write && hit(reg_addr, MODE_CTRL_OFFSET)) begin
            lin_mode_q <= reg_wdata[LIN_MODE_POS];
        end
    end

    // ************************************************************
    // Enable storage
    // ************************************************************
    // Set and clear share one flip-flop per enable; only one strobe
    // can be active per cycle, and the bank lets clear win regardless
    enable_bank u_enable_bank (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .set_mask   (set_lanes),
        .clear_mask (clear_lanes),
        .enable_q   (enable_q)
    );

    // ************************************************************
    // Read image
    // ************************************************************
    // Word image of the enables; only implemented lanes carry state,
    // so reserved lanes read zero whatever the bank holds
    always_comb begin
        enable_image                         = READ_IDLE;
        enable_image[BIT_ERROR_POS]          = enable_q[BIT_ERROR_POS];
        enable_image[PHYSICAL_BUS_ERROR_POS] = enable_q[PHYSICAL_BUS_ERROR_POS];
        enable_image[CHECKSUM_ERROR_POS]     = enable_q[CHECKSUM_ERROR_POS];
        enable_image[SYNC_FIELD_ERROR_POS]   = enable_q[SYNC_FIELD_ERROR_POS];
        enable_image[NO_RESPONSE_POS]        = enable_q[NO_RESPONSE_POS];
        enable_image[FRAMING_ERROR_POS]      = enable_q[FRAMING_ERROR_POS];
        enable_image[OVERRUN_POS]            = enable_q[OVERRUN_POS];
        enable_image[PARITY_ERROR_POS]       = enable_q[PARITY_ERROR_POS];
        enable_image[ID_POS]                 = enable_q[ID_POS];
        enable_image[RECEIVE_POS]            = enable_q[RECEIVE_POS];
        enable_image[TRANSMIT_POS]           = enable_q[TRANSMIT_POS];
        enable_image[TIMEOUT_THREE_POS]      = enable_q[TIMEOUT_THREE_POS];
        enable_image[TIMEOUT_ONE_POS]        = enable_q[TIMEOUT_ONE_POS];
        enable_image[BUS_IDLE_TIMEOUT_POS]   = enable_q[BUS_IDLE_TIMEOUT_POS];
        enable_image[WAKEUP_POS]             = enable_q[WAKEUP_POS];
        enable_image[BREAK_DETECT_POS]       = enable_q[BREAK_DETECT_POS];
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Read data select; unmapped offsets read zero
    always_comb begin
        rdata_d = READ_IDLE;
        if (reg_read) begin
            if (hit(reg_addr, ENABLE_SET_OFFSET)) begin
                rdata_d = enable_image;
            end else if (hit(reg_addr, ENABLE_CLEAR_OFFSET)) begin
                rdata_d = enable_image;
            end else if (hit(reg_addr, MODE_CTRL_OFFSET)) begin
                rdata_d = READ_IDLE;
                rdata_d[LIN_MODE_POS] = lin_mode_q;
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= READ_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata        = rdata_q;
    assign interrupt_enable = enable_q;
    assign lin_mode         = lin_mode_q;

endmodule

//--- verif/enable_clear_asserts.sv
// Checker bound onto the enable-clear register
module enable_clear_asserts
    import enable_clear_pkg::*;
(
    // Design ports
    input wire logic              ref_clk,
    input wire logic              reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [DATA_W-1:0] interrupt_enable,
    input wire logic              lin_mode
);
    logic [DATA_W-1:0] cmask_q, pmask_q;
    // Writable ones of the write data in the last two cycles, per mode
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n) {pmask_q, cmask_q} <= '0;
        else {pmask_q, cmask_q} <= {cmask_q, reg_wdata & IMPLEMENTED_MASK
            & ~(lin_mode ? SCI_ONLY_MASK : LIN_ONLY_MASK)};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence set_wr; reg_write && reg_addr == ENABLE_SET_OFFSET; endsequence
    sequence clr_wr; reg_write && reg_addr == ENABLE_CLEAR_OFFSET; endsequence
    clear_drops_a: assert property (clr_wr |=> (interrupt_enable & cmask_q) == '0)
        else $error("clear missed");
    keep_others_a: assert property (clr_wr |=>
        (interrupt_enable & ~cmask_q) == ($past(interrupt_enable) & ~cmask_q))
        else $error("other enable changed");
    set_clear_a: assert property (set_wr ##1 clr_wr |=>
        (interrupt_enable & pmask_q) == (pmask_q & ~cmask_q)) else $error("set then clear");
    idle_hold_a: assert property (!reg_write |=> $stable(interrupt_enable))
        else $error("enables moved");
    read_back_a: assert property (reg_read && reg_addr == ENABLE_CLEAR_OFFSET |=>
        reg_rdata == $past(interrupt_enable)) else $error("read data wrong");
    rdata_idle_a: assert property (!reg_read |=> reg_rdata == '0)
        else $error("read data not zero");
    reserved_zero_a: assert property (
        ((interrupt_enable | reg_rdata) & ~IMPLEMENTED_MASK) == '0) else $error("reserved set");
    reset_zero_a: assert property ($rose(reset_n) |-> interrupt_enable == '0 && !lin_mode)
        else $error("reset missed");
endmodule
bind interrupt_enable_clear enable_clear_asserts chk (.ref_clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .interrupt_enable, .lin_mode);

//--- verif/interrupt_enable_clear_tb.sv
// Bench for the interrupt enable clear register
module interrupt_enable_clear_tb
    import enable_clear_pkg::*;
();
    timeunit 1ns / 100ps;
    localparam logic [7:0] CLR = ENABLE_CLEAR_OFFSET, SET = ENABLE_SET_OFFSET;
    // Design ports, idle at time zero
    logic        ref_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, lin_mode;
    logic        md_seen;
    logic [7:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, interrupt_enable, rd_seen, en_seen;
    int          failures = 0, n_compared = 0;
    interrupt_enable_clear dut (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .interrupt_enable, .lin_mode);
    initial forever #4 ref_clk = ~ref_clk; // Clock
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        failures += int'(got !== exp);
        if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    endtask
    task automatic bus(logic w, logic r, logic [7:0] a, logic [31:0] d); // One port cycle
        {reg_write, reg_read, reg_addr, reg_wdata} <= {w, r, a, d};
        #1;
        {rd_seen, en_seen, md_seen} = {reg_rdata, interrupt_enable, lin_mode};
        @(posedge ref_clk);
    endtask
    task automatic expect_en(logic [31:0] exp); // Port, read back, idle
        bus(0, 1, CLR, '0);
        bus(0, 0, CLR, '0);
        cmp("enables", exp, en_seen);
        cmp("read data", exp, rd_seen);
        bus(0, 0, CLR, '0);
        cmp("read idle", '0, rd_seen);
    endtask
    task automatic t_reset(int n);
        reset_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        reset_n <= 1'b1;
        expect_en('0);
        cmp("lin mode", 32'h0, {31'h0, md_seen});
    endtask
    task automatic t_walk(); // LIN mode: set all, clear one bit at a time
        logic [31:0] exp = IMPLEMENTED_MASK & ~SCI_ONLY_MASK;
        bus(1, 0, MODE_CTRL_OFFSET, 32'h1);
        bus(1, 0, SET, '1);
        for (int i = 31; i >= 0; i--) begin
            bus(1, 0, CLR, 32'h1 << i);
            exp &= ~(32'h1 << i);
            expect_en(exp);
        end
    endtask
    task automatic t_gate(); // Mode gating both ways, unmapped write
        bus(1, 0, SET, '1);
        bus(1, 0, MODE_CTRL_OFFSET, '0);
        bus(1, 0, CLR, '1);
        expect_en(LIN_ONLY_MASK);
        cmp("lin mode", 32'h0, {31'h0, md_seen});
        bus(1, 0, SET, '1);
        bus(1, 0, MODE_CTRL_OFFSET, 32'h1);
        bus(1, 0, CLR, '1);
        bus(1, 0, 8'h0C, '1);
        expect_en(SCI_ONLY_MASK);
        cmp("lin mode", 32'h1, {31'h0, md_seen});
        bus(0, 1, SET, '0);
        bus(0, 1, MODE_CTRL_OFFSET, '0);
        cmp("set read", SCI_ONLY_MASK, rd_seen);
        bus(0, 1, 8'h0C, '0);
        cmp("mode read", 32'h1, rd_seen);
        bus(0, 0, SET, '0);
        cmp("unmapped read", '0, rd_seen);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin // Watchdog
        #20000;
        failures++;
        tally_and_finish();
    end
    initial begin // Main sequence
        @(posedge ref_clk);
        t_reset(6);
        t_walk();
        t_gate();
        t_reset(2);
        tally_and_finish();
    end
endmodule
